// *** motor_cfg_consts.vh ***
// Offsets, field layout, reset values and codes of the motor driver configuration bank
// Function
// R1: Lock code 011b unlocks all registers; codes other than 011b/110b keep lock state.
// R2: Lock code 110b locks; while locked only lock field writes are accepted.
// R3: Writing 1 to fault_clear clears latched faults; bit returns to 0 alone.
// R4: Two-bit input scheme: six, six limited, three, three limited; resets to 0.
// R5: serial_out_drive 0 gives open-drain output, 1 push-pull; resets to 1.
// R6: Two-bit edge rate selects 25, 50, 125, 200 V/us; resets to 0.
// R7: Full-duty frequency bit selects 20 kHz at 0, 40 kHz at 1.
// R8: Overvoltage enable resets to 1; level select picks 34 V or 22 V.
// R9: Serial faults kept off fault pin when report disabled; warnings shown when enabled.
// R10: bridge_hiz 1 places all bridge FETs in high impedance; 0 no effect.
// R11: Cycle clear bit 1 lets overcurrent clear on PWM cycle change.
// R12: Two-bit overcurrent filter selects 0.2, 0.6, 1.25, 1.6 us; resets to 1.
// R13: Retry time bit selects 5 ms at 0, 500 ms at 1.
// R14: Overcurrent threshold bit selects 16 A at 0, 24 A at 1.
// R15: Overcurrent response: latched, retrying, report only, or nothing.
// R16: Recirculation bit selects brake at 0, coast at 1 during current limit.
// R17: Independent enables for asynchronous (bit 3) and synchronous (bit 2) rectification.
// R18: Two-bit sense gain selects 0.15, 0.3, 0.6, 1.2 V/A.
// R19: Regulator voltage selects 3.3, 5.0, 4.0, 5.7 V; disable bit turns it off.
// R20: Regulator current limit 600 or 150 mA; sequencing disable bit.
// R21: Status flags for parity error, framing error, bad address read 1 when seen.
// R22: Status flags for memory error, regulator overcurrent/undervolt, pump undervolt; bit7 zero.
// R23: Delay compensation enable is bit 4, resets to 0.
// R24: Four-bit delay target, code 0 is 0 us, others 0.4 to 3.2 us.
// R25: Framing and address flags stay latched until fault_clear or sleep pulse.
// R26: Any access outside 0x0 to 0xC sets the address flag; the code sets it only for frames of 16 bits with good parity.
// R27: Writes to reserved or unlisted locations ignored; those read zero.
`ifndef MOTOR_CFG_CONSTS_VH
`define MOTOR_CFG_CONSTS_VH
`define ADDR_IC_STATUS    6'h00
`define ADDR_STATUS1      6'h01
`define ADDR_LINK_STATUS  6'h02
`define ADDR_LOCK_KEY     6'h03
`define ADDR_DRIVE_SCHEME 6'h04
`define ADDR_PROT_REPORT  6'h05
`define ADDR_OVERCURRENT  6'h06
`define ADDR_RECT_SENSE   6'h07
`define ADDR_REGULATOR    6'h08
`define ADDR_DELAY_COMP   6'h0c
`define ADDR_LAST         6'h0c
`define RST_LOCK_KEY      8'h00
`define RST_DRIVE_SCHEME  8'h60
`define RST_PROT_REPORT   8'h46
`define RST_OVERCURRENT   8'h10
`define RST_RECT_SENSE    8'h00
`define RST_REGULATOR     8'h00
`define RST_DELAY_COMP    8'h00
`define MASK_LOCK_KEY     8'h07
`define MASK_DRIVE_SCHEME 8'hfe
`define MASK_PROT_REPORT  8'h7f
`define MASK_OVERCURRENT  8'hff
`define MASK_RECT_SENSE   8'hff
`define MASK_REGULATOR    8'h3f
`define MASK_DELAY_COMP   8'h1f
`define LOCK_CODE_OPEN    3'b011
`define LOCK_CODE_CLOSE   3'b110
`define FRAME_BITS        5'h10
`define BIT_FAULT_CLEAR   0
`define BIT_OTP_ERR       6
`define BIT_REG_OC        5
`define BIT_REG_UV        4
`define BIT_PUMP_UV       3
`define BIT_PARITY        2
`define BIT_FRAMING       1
`define BIT_BAD_ADDR      0
`endif

// *** motor_driver_config_regs.v ***
// Serial-link configuration and status register bank of a three-phase motor driver
`timescale 1ns/100ps
`include "motor_cfg_consts.vh"
module motor_driver_config_regs (
  input  wire       CLOCK,
  input  wire       SRST,
  input  wire       CE,
  input  wire       SERIAL_CLK,
  input  wire       SERIAL_SELECT_N,
  input  wire       SERIAL_DATA_IN,
  output reg        SERIAL_DATA_OUT,
  output reg        SERIAL_DATA_OE,
  input  wire       SLEEP_IN_N,
  input  wire       OTP_ERR_IN,
  input  wire       REG_OVERCURRENT_IN,
  input  wire       REG_UNDERVOLT_IN,
  input  wire       PUMP_UNDERVOLT_IN,
  input  wire       HOT_WARN_IN,
  input  wire [7:0] IC_STATUS_IN,
  input  wire [7:0] STATUS1_IN,
  output reg        FAULT_OUT_N,
  output reg        LOCKED,
  output wire [1:0] INPUT_SCHEME,
  output wire       SERIAL_OUT_DRIVE,
  output wire [1:0] EDGE_RATE,
  output wire       FULL_DUTY_FREQ_SEL,
  output wire       OVERVOLT_LEVEL_SEL,
  output wire       OVERVOLT_PROTECT_EN,
  output wire       SERIAL_FAULT_REPORT_DIS,
  output wire       HOT_WARN_REPORT_EN,
  output wire       BRIDGE_HIZ,
  output wire       OVERCURRENT_CYCLE_CLEAR,
  output wire [1:0] OVERCURRENT_FILTER_TIME,
  output wire       OVERCURRENT_RETRY_TIME,
  output wire       OVERCURRENT_THRESHOLD,
  output wire [1:0] OVERCURRENT_RESPONSE,
  output wire       LIMIT_RECIRC_PATH,
  output wire       ASYNC_RECTIFY_EN,
  output wire       SYNC_RECTIFY_EN,
  output wire [1:0] SENSE_AMP_GAIN,
  output wire       REG_SEQUENCING_DIS,
  output wire       REG_CURRENT_LIMIT,
  output wire [1:0] REG_VOLTAGE_SEL,
  output wire       REG_DISABLE,
  output wire       DELAY_COMP_EN,
  output wire [3:0] DELAY_COMP_TARGET
);

  // Control registers; reserved read-only bits are held at zero by the masks
  reg [7:0] lock_key_ctrl;
  reg [7:0] drive_scheme_ctrl;
  reg [7:0] protection_report_ctrl;
  reg [7:0] overcurrent_ctrl;
  reg [7:0] rectify_sense_ctrl;
  reg [7:0] regulator_ctrl;
  reg [7:0] delay_comp_ctrl;
  reg [7:0] link_supply_fault_status;

  // Two-stage synchronisers for the serial, sleep, supply-fault and warning pins; IC_STATUS_IN and STATUS1_IN are not synchronised
  reg [8:0] sync_meta;
  reg [8:0] sync_out;
  reg       sclk_prev;
  reg       sel_prev;
  wire      sclk_s    = sync_out[0];
  wire      sel_n_s   = sync_out[1];
  wire      sdi_s     = sync_out[2];
  wire      sleep_n_s = sync_out[3];
  wire [3:0] supply_s = sync_out[7:4];
  wire      warn_s    = sync_out[8];

  wire sclk_rise  = sclk_s & ~sclk_prev;
  wire sclk_fall  = ~sclk_s & sclk_prev;
  wire frame_open = ~sel_n_s & sel_prev;
  wire frame_shut = sel_n_s & ~sel_prev;
  wire in_frame   = ~sel_n_s;

  reg [15:0] shift_in;
  reg [4:0]  fall_cnt;
  reg [15:0] out_word;
  reg        sdo_bit;
  reg        clear_pulse;

  function [7:0] read_mux;
    input [5:0] addr;
    begin
      case (addr)
        `ADDR_IC_STATUS:    read_mux = IC_STATUS_IN;
        `ADDR_STATUS1:      read_mux = STATUS1_IN;
        `ADDR_LINK_STATUS:  read_mux = link_supply_fault_status; // R21 R22
        `ADDR_LOCK_KEY:     read_mux = lock_key_ctrl;
        `ADDR_DRIVE_SCHEME: read_mux = drive_scheme_ctrl;
        `ADDR_PROT_REPORT:  read_mux = protection_report_ctrl;
        `ADDR_OVERCURRENT:  read_mux = overcurrent_ctrl;
        `ADDR_RECT_SENSE:   read_mux = rectify_sense_ctrl;
        `ADDR_REGULATOR:    read_mux = regulator_ctrl;
        `ADDR_DELAY_COMP:   read_mux = delay_comp_ctrl;
        default:            read_mux = 8'h00; // R27
      endcase
    end
  endfunction

  // Merges written data into the writable bits only
  function [7:0] merge;
    input [7:0] old;
    input [7:0] data;
    input [7:0] mask;
    begin
      merge = (old & ~mask) | (data & mask);
    end
  endfunction

  // Frame decode at the closing edge of select
  wire       frame_full  = (fall_cnt == `FRAME_BITS);
  wire       parity_ok   = ~(^shift_in);
  wire       is_write    = ~shift_in[15];
  wire [5:0] frame_addr  = shift_in[14:9];
  wire [7:0] frame_data  = shift_in[7:0];
  wire       addr_bad    = (frame_addr > `ADDR_LAST);
  wire       good_frame  = frame_shut & frame_full & parity_ok;
  wire       set_framing = frame_shut & ~frame_full;
  wire       set_parity  = frame_shut & frame_full & ~parity_ok;
  wire       set_badaddr = good_frame & addr_bad; // R26
  wire       do_write    = good_frame & ~addr_bad & is_write;
  wire       wr_lock     = do_write & (frame_addr == `ADDR_LOCK_KEY);
  wire       wr_other    = do_write & ~LOCKED & (frame_addr != `ADDR_LOCK_KEY); // R2

  wire [2:0] new_lock_code = frame_data[2:0];
  wire       next_locked = (wr_lock & (new_lock_code == `LOCK_CODE_OPEN)) ? 1'b0 : // R1
                           (wr_lock & (new_lock_code == `LOCK_CODE_CLOSE)) ? 1'b1 : // R2
                           LOCKED; // R1

  always @(posedge CLOCK) begin
    if (SRST) begin
      // Idle pin levels in both stages, so no false select edge follows reset
      sync_meta <= 9'h00a;
      sync_out  <= 9'h00a;
      sclk_prev <= 1'b0;
      sel_prev  <= 1'b1;
    end else if (CE) begin
      sync_meta <= {HOT_WARN_IN, OTP_ERR_IN, REG_OVERCURRENT_IN, REG_UNDERVOLT_IN,
                    PUMP_UNDERVOLT_IN, SLEEP_IN_N, SERIAL_DATA_IN, SERIAL_SELECT_N, SERIAL_CLK};
      sync_out  <= sync_meta;
      sclk_prev <= sclk_s;
      sel_prev  <= sel_n_s;
    end
  end

  // Serial shifter: capture on falling clock, launch on rising clock, MSB first
  always @(posedge CLOCK) begin
    if (SRST) begin
      shift_in <= 16'h0000;
      fall_cnt <= 5'h00;
      out_word <= 16'h0000;
    end else if (CE) begin
      if (frame_open) begin
        fall_cnt <= 5'h00;
        out_word <= {IC_STATUS_IN, 8'h00};
      end else if (in_frame & sclk_fall) begin
        shift_in <= {shift_in[14:0], sdi_s};
        if (fall_cnt != 5'h1f)
          fall_cnt <= fall_cnt + 5'h01;
        // Address is complete with the seventh capture and is looked up at the eighth; old contents go out for writes too
        if (fall_cnt == 5'h07)
          out_word[7:0] <= read_mux(shift_in[5:0]);
      end
    end
  end

  // Output pin is registered; open-drain only ever pulls low
  reg next_sdo_bit;
  always @* begin
    next_sdo_bit = sdo_bit;
    if (frame_open)
      next_sdo_bit = IC_STATUS_IN[7];
    else if (in_frame & sclk_rise & (fall_cnt < `FRAME_BITS))
      next_sdo_bit = out_word[4'hf - fall_cnt[3:0]];
  end

  always @(posedge CLOCK) begin
    if (SRST) begin
      sdo_bit         <= 1'b1;
      SERIAL_DATA_OUT <= 1'b0;
      SERIAL_DATA_OE  <= 1'b0;
    end else if (CE) begin
      sdo_bit <= next_sdo_bit;
      if (SERIAL_OUT_DRIVE) begin
        SERIAL_DATA_OUT <= next_sdo_bit; // R5
        SERIAL_DATA_OE  <= in_frame;
      end else begin
        SERIAL_DATA_OUT <= 1'b0; // R5
        SERIAL_DATA_OE  <= in_frame & ~next_sdo_bit;
      end
    end
  end

  // Register bank; entering sleep restores defaults just like reset
  always @(posedge CLOCK) begin
    if (SRST | (CE & ~sleep_n_s)) begin
      LOCKED                 <= 1'b0;
      lock_key_ctrl          <= `RST_LOCK_KEY;
      drive_scheme_ctrl      <= `RST_DRIVE_SCHEME; // R4 R5 R6
      protection_report_ctrl <= `RST_PROT_REPORT; // R8 R9
      overcurrent_ctrl       <= `RST_OVERCURRENT; // R12
      rectify_sense_ctrl     <= `RST_RECT_SENSE;
      regulator_ctrl         <= `RST_REGULATOR;
      delay_comp_ctrl        <= `RST_DELAY_COMP; // R23
      clear_pulse            <= 1'b0;
    end else if (CE) begin
      LOCKED      <= next_locked;
      clear_pulse <= 1'b0; // R3
      if (wr_lock)
        lock_key_ctrl <= merge(lock_key_ctrl, frame_data, `MASK_LOCK_KEY);
      if (wr_other) begin
        case (frame_addr)
          `ADDR_DRIVE_SCHEME: begin
            drive_scheme_ctrl <= merge(drive_scheme_ctrl, frame_data, `MASK_DRIVE_SCHEME);
            clear_pulse       <= frame_data[`BIT_FAULT_CLEAR]; // R3
          end
          `ADDR_PROT_REPORT:
            protection_report_ctrl <= merge(protection_report_ctrl, frame_data,
                                            `MASK_PROT_REPORT);
          `ADDR_OVERCURRENT:
            overcurrent_ctrl <= merge(overcurrent_ctrl, frame_data, `MASK_OVERCURRENT);
          `ADDR_RECT_SENSE:
            rectify_sense_ctrl <= merge(rectify_sense_ctrl, frame_data, `MASK_RECT_SENSE);
          `ADDR_REGULATOR:
            regulator_ctrl <= merge(regulator_ctrl, frame_data, `MASK_REGULATOR);
          `ADDR_DELAY_COMP:
            delay_comp_ctrl <= merge(delay_comp_ctrl, frame_data, `MASK_DELAY_COMP); // R24
          default: ; // R27
        endcase
      end
    end
  end

  // Latched fault flags; a new event in the clearing cycle still sets its flag
  wire [7:0] flag_set = {1'b0, supply_s, set_parity, set_framing, set_badaddr}; // R21 R22
  always @(posedge CLOCK) begin
    if (SRST | (CE & ~sleep_n_s)) begin
      link_supply_fault_status <= 8'h00; // R25
    end else if (CE) begin
      if (clear_pulse)
        link_supply_fault_status <= flag_set; // R3 R25
      else
        link_supply_fault_status <= link_supply_fault_status | flag_set; // R25
    end
  end

  // Fault pin: serial faults gated by the report disable, warnings by the report enable
  wire serial_fault = link_supply_fault_status[`BIT_PARITY] |
                      link_supply_fault_status[`BIT_FRAMING] |
                      link_supply_fault_status[`BIT_BAD_ADDR];
  wire supply_fault = |link_supply_fault_status[`BIT_OTP_ERR:`BIT_PUMP_UV];
  always @(posedge CLOCK) begin
    if (SRST) begin
      FAULT_OUT_N <= 1'b1;
    end else if (CE) begin
      FAULT_OUT_N <= ~((serial_fault & ~SERIAL_FAULT_REPORT_DIS) | // R9
                       (warn_s & HOT_WARN_REPORT_EN) | supply_fault); // R9
    end
  end

  // Field outputs come straight from the register flip-flops
  assign INPUT_SCHEME            = drive_scheme_ctrl[2:1]; // R4
  assign SERIAL_OUT_DRIVE        = drive_scheme_ctrl[5]; // R5
  assign EDGE_RATE               = drive_scheme_ctrl[4:3]; // R6
  assign FULL_DUTY_FREQ_SEL      = protection_report_ctrl[4]; // R7
  assign OVERVOLT_LEVEL_SEL      = protection_report_ctrl[3]; // R8
  assign OVERVOLT_PROTECT_EN     = protection_report_ctrl[2]; // R8
  assign SERIAL_FAULT_REPORT_DIS = protection_report_ctrl[1]; // R9
  assign HOT_WARN_REPORT_EN      = protection_report_ctrl[0]; // R9
  assign BRIDGE_HIZ              = overcurrent_ctrl[7]; // R10
  assign OVERCURRENT_CYCLE_CLEAR = overcurrent_ctrl[6]; // R11
  assign OVERCURRENT_FILTER_TIME = overcurrent_ctrl[5:4]; // R12
  assign OVERCURRENT_RETRY_TIME  = overcurrent_ctrl[3]; // R13
  assign OVERCURRENT_THRESHOLD   = overcurrent_ctrl[2]; // R14
  assign OVERCURRENT_RESPONSE    = overcurrent_ctrl[1:0]; // R15
  assign LIMIT_RECIRC_PATH       = rectify_sense_ctrl[6]; // R16
  assign ASYNC_RECTIFY_EN        = rectify_sense_ctrl[3]; // R17
  assign SYNC_RECTIFY_EN         = rectify_sense_ctrl[2]; // R17
  assign SENSE_AMP_GAIN          = rectify_sense_ctrl[1:0]; // R18
  assign REG_SEQUENCING_DIS      = regulator_ctrl[4]; // R20
  assign REG_CURRENT_LIMIT       = regulator_ctrl[3]; // R20
  assign REG_VOLTAGE_SEL         = regulator_ctrl[2:1]; // R19
  assign REG_DISABLE             = regulator_ctrl[0]; // R19
  assign DELAY_COMP_EN           = delay_comp_ctrl[4]; // R23
  assign DELAY_COMP_TARGET       = delay_comp_ctrl[3:0]; // R24

endmodule // motor_driver_config_regs

// *** motor_driver_config_regs_sva.sv ***
// Concurrent checks on the port behaviour of the configuration bank
`timescale 1ns/100ps
module motor_driver_config_regs_sva (
  input wire       CLOCK,
  input wire       SRST,
  input wire       CE,
  input wire       SERIAL_SELECT_N,
  input wire       SERIAL_DATA_OUT,
  input wire       SERIAL_DATA_OE,
  input wire       SLEEP_IN_N,
  input wire       REG_UNDERVOLT_IN,
  input wire       HOT_WARN_IN,
  input wire       FAULT_OUT_N,
  input wire       LOCKED,
  input wire       SERIAL_OUT_DRIVE,
  input wire       OVERVOLT_PROTECT_EN,
  input wire       SERIAL_FAULT_REPORT_DIS,
  input wire       HOT_WARN_REPORT_EN,
  input wire       BRIDGE_HIZ,
  input wire [1:0] OVERCURRENT_FILTER_TIME,
  input wire [1:0] OVERCURRENT_RESPONSE,
  input wire [3:0] DELAY_COMP_TARGET
);
  // Sample of field ports; fault-pin checks count only cycles with the clock enable high
  wire [12:0] cfg = {SERIAL_OUT_DRIVE, OVERVOLT_PROTECT_EN, SERIAL_FAULT_REPORT_DIS,
                     HOT_WARN_REPORT_EN, BRIDGE_HIZ, OVERCURRENT_FILTER_TIME,
                     OVERCURRENT_RESPONSE, DELAY_COMP_TARGET};
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  a_reset_image: assert property ($past(SRST) |-> cfg == 13'h1c40 && !LOCKED)
    else $error("field ports not at defaults after reset");
  a_sleep_default: assert property ((!SLEEP_IN_N && CE) [*5] |-> cfg == 13'h1c40 && !LOCKED)
    else $error("sleep did not restore defaults");
  a_lock_freeze: assert property ((LOCKED && SLEEP_IN_N) [*5] |=> $stable(cfg))
    else $error("field changed while locked");
  a_frame_quiet: assert property ((!SERIAL_SELECT_N && SLEEP_IN_N) [*8] |=> $stable(cfg))
    else $error("field changed inside a frame");
  a_idle_release: assert property (SERIAL_SELECT_N [*6] |-> !SERIAL_DATA_OE)
    else $error("data out driven outside a frame");
  a_open_drain: assert property (SERIAL_DATA_OE && !SERIAL_OUT_DRIVE |-> !SERIAL_DATA_OUT)
    else $error("open-drain output drove high");
  a_supply_pin: assert property ((REG_UNDERVOLT_IN && SLEEP_IN_N && CE) [*8] |-> !FAULT_OUT_N)
    else $error("supply fault not on fault pin");
  a_warn_pin: assert property ((HOT_WARN_IN && HOT_WARN_REPORT_EN && SLEEP_IN_N && CE) [*6]
    |-> !FAULT_OUT_N)
    else $error("reported warning not on fault pin");
endmodule // motor_driver_config_regs_sva
bind motor_driver_config_regs motor_driver_config_regs_sva chk (.CLOCK, .SRST, .CE, .SERIAL_SELECT_N,
  .SERIAL_DATA_OUT, .SERIAL_DATA_OE, .SLEEP_IN_N, .REG_UNDERVOLT_IN, .HOT_WARN_IN, .FAULT_OUT_N,
  .LOCKED, .SERIAL_OUT_DRIVE, .OVERVOLT_PROTECT_EN, .SERIAL_FAULT_REPORT_DIS, .HOT_WARN_REPORT_EN,
  .BRIDGE_HIZ, .OVERCURRENT_FILTER_TIME, .OVERCURRENT_RESPONSE, .DELAY_COMP_TARGET);

// *** motor_driver_config_regs_tb_top.sv ***
// Self-checking bench for the motor driver configuration register bank
`timescale 1ns/100ps
module motor_driver_config_regs_tb_top;
  reg        CLOCK = 1'b0, SRST = 1'b1, CE = 1'b1, SLEEP_IN_N = 1'b1, HOT_WARN_IN = 1'b0;
  reg        OTP_ERR_IN = 1'b0, REG_OVERCURRENT_IN = 1'b0, REG_UNDERVOLT_IN = 1'b0;
  reg        PUMP_UNDERVOLT_IN = 1'b0;
  reg  [7:0] IC_STATUS_IN = 8'h5a, STATUS1_IN = 8'h3c;
  wire       SERIAL_CLK, SERIAL_SELECT_N, SERIAL_DATA_IN, SERIAL_DATA_OUT, SERIAL_DATA_OE;
  wire       FAULT_OUT_N, LOCKED, SERIAL_OUT_DRIVE, FULL_DUTY_FREQ_SEL, OVERVOLT_LEVEL_SEL;
  wire       OVERVOLT_PROTECT_EN, SERIAL_FAULT_REPORT_DIS, HOT_WARN_REPORT_EN, BRIDGE_HIZ;
  wire       OVERCURRENT_CYCLE_CLEAR, OVERCURRENT_RETRY_TIME, OVERCURRENT_THRESHOLD, REG_DISABLE;
  wire       LIMIT_RECIRC_PATH, ASYNC_RECTIFY_EN, SYNC_RECTIFY_EN, REG_SEQUENCING_DIS;
  wire       REG_CURRENT_LIMIT, DELAY_COMP_EN;
  wire [1:0] INPUT_SCHEME, EDGE_RATE, OVERCURRENT_FILTER_TIME, OVERCURRENT_RESPONSE;
  wire [1:0] SENSE_AMP_GAIN, REG_VOLTAGE_SEL;
  wire [3:0] DELAY_COMP_TARGET;
  wire       sdo_line = SERIAL_DATA_OE ? SERIAL_DATA_OUT : 1'b1;  // Pulled up when released
  integer    mismatches = 0, n_checks = 0, cycles = 0, i;
  reg [15:0] resp;
  reg [39:0] rows [0:8];  // Address, reset value, write value, readback, field-port mask
  reg  [7:0] a, m;

  motor_driver_config_regs dut (.*);
  serial_master_model master (.CLOCK, .sdo_line, .sclk(SERIAL_CLK), .select_n(SERIAL_SELECT_N),
                              .sdi(SERIAL_DATA_IN));
  always #25 CLOCK = ~CLOCK;
  // The run needs about 6000 cycles; the ceiling leaves room
  always @(posedge CLOCK) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_of_test;
    end
  end
  function [15:0] frame(input rd, input [5:0] ad, input [7:0] d);
    frame = {rd, ad, ^{rd, ad, d}, d};  // Even ones over the whole word
  endfunction
  function [7:0] fields(input [5:0] ad);
    case (ad)
      6'h04: fields = {2'b00, SERIAL_OUT_DRIVE, EDGE_RATE, INPUT_SCHEME, 1'b0};
      6'h05: fields = {3'b000, FULL_DUTY_FREQ_SEL, OVERVOLT_LEVEL_SEL, OVERVOLT_PROTECT_EN,
                       SERIAL_FAULT_REPORT_DIS, HOT_WARN_REPORT_EN};
      6'h06: fields = {BRIDGE_HIZ, OVERCURRENT_CYCLE_CLEAR, OVERCURRENT_FILTER_TIME,
                       OVERCURRENT_RETRY_TIME, OVERCURRENT_THRESHOLD, OVERCURRENT_RESPONSE};
      6'h07: fields = {1'b0, LIMIT_RECIRC_PATH, 2'b00, ASYNC_RECTIFY_EN, SYNC_RECTIFY_EN,
                       SENSE_AMP_GAIN};
      6'h08: fields = {3'b000, REG_SEQUENCING_DIS, REG_CURRENT_LIMIT, REG_VOLTAGE_SEL, REG_DISABLE};
      6'h0c: fields = {3'b000, DELAY_COMP_EN, DELAY_COMP_TARGET};
      default: fields = 8'h00;
    endcase
  endfunction
  task check(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task access(input rd, input [5:0] ad, input [7:0] d);
    master.xfer(frame(rd, ad, d), 16, resp);
  endtask
  task pins(input [3:0] v);
    begin
      @(posedge CLOCK);
      {OTP_ERR_IN, REG_OVERCURRENT_IN, REG_UNDERVOLT_IN, PUMP_UNDERVOLT_IN} <= v;
      repeat (10) @(posedge CLOCK);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    rows[0] = 40'h04_60_ff_fe_3e;
    rows[1] = 40'h05_46_ff_7f_1f;
    rows[2] = 40'h06_10_a5_a5_ff;
    rows[3] = 40'h07_00_ff_ff_4f;
    rows[4] = 40'h08_00_ff_3f_1f;
    rows[5] = 40'h0c_00_ff_1f_1f;
    rows[6] = 40'h03_00_ff_07_00;
    rows[7] = 40'h09_00_ff_00_00;
    rows[8] = 40'h01_3c_ff_3c_00;
    repeat (5) @(posedge CLOCK);
    SRST <= 1'b0;
    repeat (4) @(posedge CLOCK);
    for (i = 0; i < 9; i = i + 1) begin
      a = rows[i][39:32];
      m = rows[i][7:0];
      access(1'b0, a[5:0], rows[i][23:16]);
      check(resp[7:0], rows[i][31:24]);
      access(1'b1, a[5:0], 8'h00);
      check(resp, {8'h5a, rows[i][15:8]});
      check(fields(a[5:0]) & m, rows[i][15:8] & m);
    end
    $display("register table test done");
    @(posedge CLOCK) HOT_WARN_IN <= 1'b1;
    repeat (8) @(posedge CLOCK);
    check(FAULT_OUT_N, 1'b0);
    HOT_WARN_IN <= 1'b0;
    repeat (8) @(posedge CLOCK);
    check(FAULT_OUT_N, 1'b1);
    $display("warning report test done");
    access(1'b0, 6'h03, 8'h06);
    check(LOCKED, 1'b1);
    access(1'b0, 6'h06, 8'h00);
    access(1'b1, 6'h06, 8'h00);
    check(resp[7:0], 8'ha5);
    access(1'b0, 6'h03, 8'h05);
    check(LOCKED, 1'b1);
    access(1'b0, 6'h03, 8'h03);
    check(LOCKED, 1'b0);
    $display("lock test done");
    master.xfer(frame(1'b1, 6'h05, 8'h00), 15, resp);
    master.xfer(frame(1'b1, 6'h05, 8'h00) ^ 16'h0100, 16, resp);
    access(1'b1, 6'h0d, 8'h00);
    access(1'b1, 6'h02, 8'h00);
    check(resp[7:0], 8'h07);
    check(FAULT_OUT_N, 1'b1);
    access(1'b0, 6'h04, 8'h61);
    access(1'b1, 6'h02, 8'h00);
    check(resp[7:0], 8'h00);
    master.xfer(frame(1'b1, 6'h02, 8'h00), 17, resp);
    pins(4'he);
    check(FAULT_OUT_N, 1'b0);
    pins(4'h0);
    access(1'b1, 6'h02, 8'h00);
    check(resp[7:0], 8'h72);
    pins(4'h1);
    pins(4'h0);
    access(1'b1, 6'h02, 8'h00);
    check(resp[7:0], 8'h7a);
    $display("fault flag test done");
    @(posedge CLOCK) SLEEP_IN_N <= 1'b0;
    repeat (8) @(posedge CLOCK);
    SLEEP_IN_N <= 1'b1;
    repeat (8) @(posedge CLOCK);
    check(FAULT_OUT_N, 1'b1);
    access(1'b1, 6'h02, 8'h00);
    check(resp[7:0], 8'h00);
    access(1'b1, 6'h06, 8'h00);
    check(resp[7:0], 8'h10);
    $display("sleep test done");
    access(1'b0, 6'h04, 8'h40);
    check(SERIAL_OUT_DRIVE, 1'b0);
    access(1'b1, 6'h04, 8'h00);
    check(resp, 16'h5a40);
    $display("open-drain test done");
    CE <= 1'b0;
    SLEEP_IN_N <= 1'b0;
    repeat (8) @(posedge CLOCK);
    SLEEP_IN_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    CE <= 1'b1;
    repeat (6) @(posedge CLOCK);
    check(SERIAL_OUT_DRIVE, 1'b0);
    $display("clock enable test done");
    access(1'b0, 6'h03, 8'h06);
    check(LOCKED, 1'b1);
    SRST <= 1'b1;
    repeat (3) @(posedge CLOCK);
    SRST <= 1'b0;
    repeat (4) @(posedge CLOCK);
    check({LOCKED, SERIAL_OUT_DRIVE, FAULT_OUT_N}, 3'b011);
    access(1'b1, 6'h05, 8'h00);
    check(resp, 16'h5a46);
    $display("mid-run reset test done");
    end_of_test;
  end
endmodule // motor_driver_config_regs_tb_top

// *** serial_master_model.sv ***
// Serial controller model that frames words into the configuration bank
`timescale 1ns/100ps
module serial_master_model (
  input  wire CLOCK,
  input  wire sdo_line,
  output reg  sclk = 1'b0,
  output reg  select_n = 1'b1,
  output reg  sdi = 1'b0
);
  // Clock low at both select edges; the bank answers a few cycles after each
  // rise, so the pin is sampled late in the low half
  task xfer(input [15:0] w, input integer nb, output [15:0] r);
    integer i;
    begin
      r = 16'h0000;
      @(posedge CLOCK);
      select_n <= 1'b0;
      repeat (4) @(posedge CLOCK);
      for (i = 0; i < nb; i = i + 1) begin
        sdi <= w[15 - (i % 16)];
        sclk <= 1'b1;
        repeat (4) @(posedge CLOCK);
        sclk <= 1'b0;
        repeat (3) @(posedge CLOCK);
        r = {r[14:0], sdo_line};
        @(posedge CLOCK);
      end
      select_n <= 1'b1;
      sdi <= ~sdi;  // Released line shows no stale bit
      repeat (12) @(posedge CLOCK);
    end
  endtask
endmodule // serial_master_model
